// ===== hdl/input_sync.sv
module input_sync
    import selector_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, val_reg;
    logic [WIDTH-1:0] val_next;

    // -----------------------------
    // Three stages, accept when last two agree
    // -----------------------------
    always_comb
    begin
        val_next = val_reg;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
                val_next[i] = s3_reg[i];
        end
    end

    // First stage feeds only the second one
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            val_reg <= '0;
        end
        else
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            val_reg <= val_next;
        end
    end

    assign sync_out = val_reg;
endmodule

// ===== hdl/power_source_selector.sv
module power_source_selector
    import selector_pkg::*;
#(
    parameter bit SECOND_VARIANT = 1'b0
)(
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire logic ADAPTER_SENSE_OK_IN,
    input wire logic ADAPTER_SELECT_REQUEST_IN,
    input wire logic BATTERY_PRESENT_IN,
    input wire logic BATTERY_DEPLETED_IN,
    input wire logic BATTERY_DEEP_IN,
    input wire logic SYSTEM_VOLTAGE_HIGH_IN,
    input wire logic SYSTEM_SENSE_GROUNDED_IN,
    input wire logic ADAPTER_SWITCH_ON_IN,
    input wire logic BATTERY_SWITCH_ON_IN,
    output logic ADAPTER_SWITCH_DRIVE_OUT,
    output logic BATTERY_SWITCH_DRIVE_OUT,
    output logic ADAPTER_PRESENT_FLAG_OUT,
    output logic ALARM_OUT,
    output logic CHARGE_SUSPEND_OUT,
    output logic SLEEP_OUT
);
    // -----------------------------
    // Input synchronisation
    // -----------------------------
    sense_t raw;
    sense_t sn;
    logic [SENSE_W-1:0] sync_bits;

    // Comparator results and host select, all asynchronous pins
    always_comb
    begin
        raw.adapter_sense_ok = ADAPTER_SENSE_OK_IN;
        raw.adapter_select_request = ADAPTER_SELECT_REQUEST_IN;
        raw.battery_present = BATTERY_PRESENT_IN;
        raw.battery_depleted = BATTERY_DEPLETED_IN;
        raw.battery_deep = BATTERY_DEEP_IN;
        raw.system_voltage_high = SYSTEM_VOLTAGE_HIGH_IN;
        raw.system_sense_grounded = SYSTEM_SENSE_GROUNDED_IN;
        raw.adapter_switch_on = ADAPTER_SWITCH_ON_IN;
        raw.battery_switch_on = BATTERY_SWITCH_ON_IN;
    end

    input_sync #(
        .WIDTH(SENSE_W)
    ) u_sync (
        .clk_in(CORE_CLK_IN),
        .reset_in(RESET_IN),
        .async_in(raw),
        .sync_out(sync_bits)
    );

    assign sn = sense_t'(sync_bits);

    // -----------------------------
    // Selection decision
    // -----------------------------
    sel_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic lock_reg, lock_next;
    logic present_reg, present_next;
    logic loss_reg, loss_next;
    logic vs_fault_reg, vs_fault_next;
    logic ac_drv_reg, ac_drv_next;
    logic bat_drv_reg, bat_drv_next;
    logic flag_reg, flag_next;
    logic alarm_reg, alarm_next;
    logic suspend_reg, suspend_next;
    logic sleep_reg, sleep_next;
    logic ac, cnt_done, force_ac, go_bat, vs_block, mismatch;

    // Below-threshold sense is loss, whatever the adapter really does
    assign ac = sn.adapter_sense_ok;
    assign cnt_done = (cnt_reg == BREAK_CNT);
    // Grounded sense pin switches the shorted-switch check off
    assign vs_block = ac && sn.system_voltage_high && !sn.system_sense_grounded;

    // Reasons that override a manual battery choice
    always_comb
    begin
        force_ac = 1'b0;
        if (ac)
        begin
            if (!sn.battery_present)
                force_ac = 1'b1;
            else if (SECOND_VARIANT)
                force_ac = sn.battery_depleted || lock_reg;
            else
                force_ac = sn.battery_deep;
        end
    end

    // Battery when adapter lost, or when host holds select low
    assign go_bat = !ac || (!sn.adapter_select_request && !force_ac && !vs_fault_reg);

    // Feedback check only after the switches had time to settle
    always_comb
    begin
        mismatch = 1'b0;
        if (cnt_done && (state_reg == ST_ADAPTER || state_reg == ST_BATTERY))
            mismatch = (sn.adapter_switch_on != (ac_drv_reg == DRIVE_ON))
                || (sn.battery_switch_on != (bat_drv_reg == DRIVE_ON));
    end

    // -----------------------------
    // Selector state machine
    // -----------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:
            begin
                if (cnt_done)
                    state_next = go_bat ? ST_BATTERY : ST_ADAPTER;
            end
            ST_ADAPTER:
            begin
                if (go_bat)
                    state_next = ST_BREAK;
            end
            ST_BREAK:
            begin
                // Both switches off here before the battery one closes
                if (!go_bat)
                    state_next = ST_ADAPTER;
                else if (cnt_done)
                    state_next = vs_block ? ST_ADAPTER : ST_BATTERY;
            end
            ST_BATTERY:
            begin
                if (!go_bat)
                    state_next = ST_TO_ADAPTER;
            end
            ST_TO_ADAPTER:
            begin
                if (go_bat)
                    state_next = ST_BATTERY;
                else if (cnt_done)
                    state_next = ST_ADAPTER;
            end
            default:
            begin
                state_next = ST_OFF;
            end
        endcase
    end

    // -----------------------------
    // Latches, counter and outputs
    // -----------------------------
    always_comb
    begin
        cnt_next = (state_next != state_reg) ? '0 : (cnt_done ? cnt_reg : cnt_reg + 1'b1);
        present_next = sn.battery_present;
        // In the second variant a reinserted battery stays idle until the adapter goes away
        lock_next = lock_reg;
        if (SECOND_VARIANT && sn.battery_present && !present_reg && ac)
            lock_next = 1'b1;
        else if (!ac)
            lock_next = 1'b0;
        // Blocked switchover is held until the host raises the select request again or the adapter goes away
        vs_fault_next = vs_fault_reg;
        if (state_reg == ST_BREAK && cnt_done && vs_block)
            vs_fault_next = 1'b1;
        else if (sn.adapter_select_request || !ac)
            vs_fault_next = 1'b0;
        // Loss alarm: a new loss wins over a clear in the same cycle
        loss_next = loss_reg;
        if (!ac && (state_reg == ST_ADAPTER || state_reg == ST_BREAK))
            loss_next = 1'b1;
        else if (ac && sn.adapter_select_request)
            loss_next = 1'b0;
        ac_drv_next = (state_next == ST_ADAPTER) ? DRIVE_ON : DRIVE_OFF;
        bat_drv_next = (state_next == ST_BATTERY) ? DRIVE_ON : DRIVE_OFF;
        flag_next = ac;
        alarm_next = sn.battery_depleted || loss_next
            || (!SECOND_VARIANT && (mismatch || vs_fault_next));
        suspend_next = (state_next != ST_ADAPTER);
        sleep_next = !ac;
    end

    // Reset leaves both switches open
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RESET_IN)
        begin
            state_reg <= ST_OFF;
            cnt_reg <= '0;
            lock_reg <= 1'b0;
            present_reg <= 1'b0;
            vs_fault_reg <= 1'b0;
            loss_reg <= 1'b0;
            ac_drv_reg <= DRIVE_OFF;
            bat_drv_reg <= DRIVE_OFF;
            flag_reg <= 1'b0;
            alarm_reg <= 1'b0;
            suspend_reg <= 1'b1;
            sleep_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            lock_reg <= lock_next;
            present_reg <= present_next;
            vs_fault_reg <= vs_fault_next;
            loss_reg <= loss_next;
            ac_drv_reg <= ac_drv_next;
            bat_drv_reg <= bat_drv_next;
            flag_reg <= flag_next;
            alarm_reg <= alarm_next;
            suspend_reg <= suspend_next;
            sleep_reg <= sleep_next;
        end
    end

    assign ADAPTER_SWITCH_DRIVE_OUT = ac_drv_reg;
    assign BATTERY_SWITCH_DRIVE_OUT = bat_drv_reg;
    assign ADAPTER_PRESENT_FLAG_OUT = flag_reg;
    assign ALARM_OUT = alarm_reg;
    assign CHARGE_SUSPEND_OUT = suspend_reg;
    assign SLEEP_OUT = sleep_reg;

    // -----------------------------
    // Assertions
    // -----------------------------
    sequence s_ac_open_long;
        ADAPTER_SWITCH_DRIVE_OUT [*8];
    endsequence

    sequence s_battery_closes;
        $fell(BATTERY_SWITCH_DRIVE_OUT);
    endsequence

    property p_bbm;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        !(ADAPTER_SWITCH_DRIVE_OUT == DRIVE_ON && BATTERY_SWITCH_DRIVE_OUT == DRIVE_ON);
    endproperty
    a_bbm: assert property (p_bbm) else $error("both switches on");

    property p_break_gap;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_ac_open_long ##1 s_battery_closes |-> ADAPTER_SWITCH_DRIVE_OUT;
    endproperty
    a_break_gap: assert property (p_break_gap) else $error("battery on too early");

    property p_no_short_gap;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_battery_closes |-> $past(ADAPTER_SWITCH_DRIVE_OUT, 8);
    endproperty
    a_no_short_gap: assert property (p_no_short_gap) else $error("break gap short");

    property p_flag;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        ac |=> ADAPTER_PRESENT_FLAG_OUT && !SLEEP_OUT;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");

    property p_loss;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (state_reg == ST_ADAPTER && !ac) |=> state_reg == ST_BREAK && ALARM_OUT
            && !ADAPTER_PRESENT_FLAG_OUT && SLEEP_OUT;
    endproperty
    a_loss: assert property (p_loss) else $error("adapter loss not handled");

    // Loss must last through the whole break window; the battery closes one edge after it
    property p_loss_to_bat;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (state_reg == ST_ADAPTER && !ac) ##1 !ac [*8] ##1 !ac [*3]
            |=> !BATTERY_SWITCH_DRIVE_OUT;
    endproperty
    a_loss_to_bat: assert property (p_loss_to_bat) else $error("battery not chosen");

    property p_return;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (state_reg == ST_BATTERY && ac && sn.adapter_select_request && !vs_fault_reg)
            |=> state_reg == ST_TO_ADAPTER;
    endproperty
    a_return: assert property (p_return) else $error("no return to adapter");

    property p_removed;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (state_reg == ST_BATTERY && ac && !sn.battery_present) |=> state_reg == ST_TO_ADAPTER;
    endproperty
    a_removed: assert property (p_removed) else $error("removal ignored");

    property p_suspend;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        BATTERY_SWITCH_DRIVE_OUT == DRIVE_ON |-> CHARGE_SUSPEND_OUT;
    endproperty
    a_suspend: assert property (p_suspend) else $error("charging on battery");

    property p_depleted;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        sn.battery_depleted |=> ALARM_OUT;
    endproperty
    a_depleted: assert property (p_depleted) else $error("depletion alarm missing");

    property p_deep;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (state_reg == ST_BATTERY && ac && sn.battery_present && !SECOND_VARIANT
            && sn.battery_deep) |=> state_reg == ST_TO_ADAPTER;
    endproperty
    a_deep: assert property (p_deep) else $error("deep discharge ignored");

    property p_vs_block;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (state_reg == ST_BREAK && cnt_done && vs_block) |=> state_reg == ST_ADAPTER;
    endproperty
    a_vs_block: assert property (p_vs_block) else $error("shorted switch passed");

    property p_reset_off;
        @(posedge CORE_CLK_IN)
        RESET_IN |=> ADAPTER_SWITCH_DRIVE_OUT && BATTERY_SWITCH_DRIVE_OUT;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("switch on after reset");
endmodule

// ===== hdl/selector_pkg.sv
package selector_pkg;
    // -----------------------------
    // Timing
    // -----------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BREAK_TIME_NS = 250;
    // Least time, so rounded up
    localparam int BREAK_CYCLES = (BREAK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] BREAK_CNT = CNT_W'(BREAK_CYCLES);
    localparam int SENSE_W = 9;
    // Switch drive levels: high turns the P-channel switch off
    localparam logic DRIVE_OFF = 1'b1;
    localparam logic DRIVE_ON = 1'b0;

    // -----------------------------
    // Types
    // -----------------------------
    typedef struct packed {
        logic adapter_sense_ok;
        logic adapter_select_request;
        logic battery_present;
        logic battery_depleted;
        logic battery_deep;
        logic system_voltage_high;
        logic system_sense_grounded;
        logic adapter_switch_on;
        logic battery_switch_on;
    } sense_t;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_ADAPTER = 3'h1,
        ST_BREAK = 3'h3,
        ST_BATTERY = 3'h2,
        ST_TO_ADAPTER = 3'h6
    } sel_state_t;
endpackage

// ===== tb/power_path_model.sv
module power_path_model
    import selector_pkg::*;
(
    input wire logic clk_in,
    input wire logic learn_in,
    input wire logic stuck_in,
    input wire logic adapter_drive_in,
    input wire logic battery_drive_in,
    input wire logic present_flag_in,
    output logic select_out,
    output logic adapter_on_out,
    output logic battery_on_out,
    output logic charge_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic flag_seen;

    // Host turns the charger on a cycle after it sees the adapter, off at once on loss
    assign charge_enable_out = flag_seen & present_flag_in;

    // Host keeps select low only while it runs a learn cycle
    assign select_out = ~learn_in;

    // Switch feedback lags the gate by one cycle, as a real switch would
    // A welded battery switch reports conducting whatever its gate says
    always @(posedge clk_in)
    begin
        flag_seen <= present_flag_in;
        adapter_on_out <= (adapter_drive_in == DRIVE_ON);
        battery_on_out <= stuck_in | (battery_drive_in == DRIVE_ON);
    end
endmodule

// ===== tb/tb_power_source_selector.sv
module tb_power_source_selector;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk, rst, ac, learn, batt, dep, deep, vsh, vsg, stuck;
    // Nets, since each bit is driven by a different unit
    wire [1:0] sel, aon, bon, adrv, bdrv, flag, alarm, susp, slp, en;
    wire [5:0] outs [2];
    int fails = 0;
    int num_checks = 0;

    // Clock at 40 MHz
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Unit 0 is the first variant, unit 1 the second; both get the same stimulus, each its own switch feedback
    for (genvar i = 0; i < 2; i++)
    begin : g_unit
        power_path_model u_path (.clk_in(clk), .learn_in(learn), .stuck_in(stuck),
            .adapter_drive_in(adrv[i]), .battery_drive_in(bdrv[i]), .select_out(sel[i]),
            .adapter_on_out(aon[i]), .battery_on_out(bon[i]), .present_flag_in(flag[i]),
            .charge_enable_out(en[i]));
        power_source_selector #(.SECOND_VARIANT(i == 1)) u_dut (.CORE_CLK_IN(clk),
            .RESET_IN(rst), .ADAPTER_SENSE_OK_IN(ac), .ADAPTER_SELECT_REQUEST_IN(sel[i]),
            .BATTERY_PRESENT_IN(batt), .BATTERY_DEPLETED_IN(dep), .BATTERY_DEEP_IN(deep),
            .SYSTEM_VOLTAGE_HIGH_IN(vsh), .SYSTEM_SENSE_GROUNDED_IN(vsg),
            .ADAPTER_SWITCH_ON_IN(aon[i]), .BATTERY_SWITCH_ON_IN(bon[i]),
            .ADAPTER_SWITCH_DRIVE_OUT(adrv[i]), .BATTERY_SWITCH_DRIVE_OUT(bdrv[i]),
            .ADAPTER_PRESENT_FLAG_OUT(flag[i]), .ALARM_OUT(alarm[i]),
            .CHARGE_SUSPEND_OUT(susp[i]), .SLEEP_OUT(slp[i]));
        assign outs[i] = {adrv[i], bdrv[i], flag[i], alarm[i], susp[i], slp[i]};
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Order: adapter drive, battery drive, flag, alarm, suspend, sleep
    task automatic check(input int unit, input logic [5:0] exp);
        num_checks++;
        if (outs[unit] !== exp)
        begin
            fails++;
            $display("unexpected at %0t: unit %0d outputs %b, wanted %b",
                $time, unit, outs[unit], exp);
        end
    endtask

    // Covers synchroniser, one break window and the start-up wait with margin
    task automatic settle;
        repeat (40) @(negedge clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Both switches on at once would short the adapter into the battery
    // Looked at on the falling edge, clear of the edge that moves the drives
    always @(negedge clk)
    begin
        if (!rst && ((~adrv & ~bdrv) !== 2'b00))
        begin
            fails++;
            $display("unexpected at %0t: both switches driven on", $time);
        end
        if (!rst && ((en & ~flag) !== 2'b00))
        begin
            fails++;
            $display("unexpected at %0t: charger enabled without adapter", $time);
        end
    end

    // Whole sequence takes well under 1000 cycles
    initial
    begin
        #(5000 * 25);
        fails++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {ac, learn, batt, dep, deep, vsh, vsg, stuck} = 8'h A0;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        check(0, 6'b110010);
        check(1, 6'b110010);
        rst = 1'b0;
        settle();
        check(0, 6'b011000);
        ac = 1'b0;
        settle();
        check(0, 6'b100111);
        check(1, 6'b100111);
        ac = 1'b1;
        settle();
        check(0, 6'b011000);
        check(1, 6'b011000);
        learn = 1'b1;
        settle();
        check(0, 6'b101010);
        learn = 1'b0;
        settle();
        check(0, 6'b011000);
        learn = 1'b1;
        settle();
        batt = 1'b0;
        settle();
        check(0, 6'b011000);
        check(1, 6'b011000);
        batt = 1'b1;
        settle();
        check(0, 6'b101010);
        check(1, 6'b011000);
        dep = 1'b1;
        settle();
        check(0, 6'b101110);
        check(1, 6'b011100);
        deep = 1'b1;
        settle();
        check(0, 6'b011100);
        {dep, deep, learn} = 3'h0;
        settle();
        check(0, 6'b011000);
        vsh = 1'b1;
        learn = 1'b1;
        settle();
        check(0, 6'b011100);
        learn = 1'b0;
        settle();
        vsg = 1'b1;
        learn = 1'b1;
        settle();
        check(0, 6'b101010);
        {learn, vsh, vsg} = 3'h0;
        settle();
        stuck = 1'b1;
        settle();
        check(0, 6'b011100);
        check(1, 6'b011000);
        report_and_stop();
    end
endmodule
